// File: ecaf_defs.vh
// Constants for the two-wire client address front end.
// Assumes a 25 MHz system clock; included by the front end and the bench.
`ifndef ECAF_DEFS_VH
`define ECAF_DEFS_VH
// ==========================================================================
// Timing
`define ECAF_CLK_MHZ          25
`define ECAF_HOLDOFF_US       100
`define ECAF_HOLDOFF_CYC      (`ECAF_HOLDOFF_US * `ECAF_CLK_MHZ)
// ==========================================================================
// Address byte fields
`define ECAF_TYPE_MSB         7
`define ECAF_TYPE_LSB         4
`define ECAF_HW_MSB           3
`define ECAF_HW_LSB           1
`define ECAF_RW_BIT           0
`define ECAF_TYPE_ARRAY       4'hA
`define ECAF_TYPE_REGS        4'hB
`define ECAF_CODE_MFGID       7'h7C
// High-speed code: bits 7 to 3 are 00001, bits 2 to 0 are don't care
`define ECAF_CODE_HS_MSB      5'h01
// ==========================================================================
// Access region codes
`define ECAF_RGN_NONE         3'h0
`define ECAF_RGN_ARRAY        3'h1
`define ECAF_RGN_REGS         3'h2
`define ECAF_RGN_MFGID        3'h3
`define ECAF_RGN_HSMODE       3'h4
// ==========================================================================
// Organisation
`define ECAF_PAGES            512
`define ECAF_PAGE_BYTES       128
`define ECAF_PAGE_AW          9
`define ECAF_BYTE_AW          7
`define ECAF_SERIAL_BITS      128
`define ECAF_MFGID_BITS       24
`endif

// File: ecaf_sync.v
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes clk is the system clock; no reset on the chain.
`timescale 1ns/1ps
`default_nettype none
module ecaf_sync
(
  input  wire clk,
  input  wire d,
  output reg  q
);
  reg meta_q; // First stage, read only by the second
  // ========================================================================
  // Two flops in series
  always @(posedge clk)
  begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule
`default_nettype wire

// File: ecaf_front.v
// Front end of a two-wire bus client memory: hold-off, start/stop
// detection, address byte capture and match, acknowledge and write gating.
// Assumes scl, sda and pins are asynchronous; bus clock well under clk/8.
// Overview of operation
// - Ignore bus until power-on hold-off ends
// - Match three strap pins against hardware bits
// - Protect low: array, security writes allowed
// - Protect high: block array, security, ID page writes; reads unaffected
// - Software protection mode ignores protect pin
// - Data changes only while clock low
// - Data edge with clock high: start/stop
// - Array is 512 pages of 128 bytes
// - Config register lock makes it read-only
// - Serial read-only; ID page lockable
// - Fixed 24-bit identity via reserved code
// - Address byte: seven-bit address, direction bit0
// - Bits 7-4 type, 3-1 hardware address
// - Accept reserved host code, alternate mode
// - Acknowledge only defined type identifiers
// - Direction one reads, zero writes
// - Mismatch: silent, back to standby
// - No acknowledge during self-timed write
`timescale 1ns/1ps
`default_nettype none
`include "ecaf_defs.vh"
module ecaf_front
#(
  parameter HOLDOFF_CYC = `ECAF_HOLDOFF_CYC // Power-on hold-off length
)
(
  input  wire        clk,
  input  wire        srst,
  input  wire        scl_i,           // Serial clock pin
  input  wire        sda_i,           // Serial data pin level
  output reg         sda_o,           // Serial data drive value (always 0)
  output reg         sda_oe,          // High while pulling data low
  input  wire        strap_addr_bit0, // Hardware address straps
  input  wire        strap_addr_bit1,
  input  wire        strap_addr_bit2,
  input  wire        wp_i,            // Write protect pin
  input  wire        sw_prot_mode,    // Enhanced software protection active
  input  wire        cfg_locked,      // Configuration register locked
  input  wire        id_page_locked,  // Security ID page locked
  input  wire        write_busy,      // Self-timed write running
  output reg         ready_q,         // Standby reached after hold-off
  output reg         selected_q,      // Address matched, transfer open
  output reg  [2:0]  region_q,        // Selected access region
  output reg         read_q,          // Direction bit of the address byte
  output reg         array_wr_ok_q,   // Array writes permitted
  output reg         sec_wr_ok_q,     // Security register writes permitted
  output reg         cfg_wr_ok_q,     // Configuration writes permitted
  output reg         idpg_wr_ok_q,    // ID page writes permitted
  output reg         start_q,         // One-cycle start pulse
  output reg         stop_q,          // One-cycle stop pulse
  output reg  [7:0]  addr_byte_q      // Last received address byte
);
  // ========================================================================
  // State codes, one-hot
  localparam [3:0] ST_IDLE = 4'b0001; // Standby, wait for start
  localparam [3:0] ST_ADDR = 4'b0010; // Shift address byte
  localparam [3:0] ST_ACK  = 4'b0100; // Acknowledge slot
  localparam [3:0] ST_DONE = 4'b1000; // Passed on or silent till start

  // Region decode of a complete address byte with straps
  function [2:0] decode_rgn;
    input [7:0] b;
    input [2:0] hw;
    begin
      decode_rgn = `ECAF_RGN_NONE;
      if (b[7:1] == `ECAF_CODE_MFGID)
        decode_rgn = `ECAF_RGN_MFGID;
      else if (b[7:3] == `ECAF_CODE_HS_MSB)
        decode_rgn = `ECAF_RGN_HSMODE;
      else if (b[`ECAF_HW_MSB:`ECAF_HW_LSB] != hw)
        decode_rgn = `ECAF_RGN_NONE;
      else if (b[`ECAF_TYPE_MSB:`ECAF_TYPE_LSB] == `ECAF_TYPE_ARRAY)
        decode_rgn = `ECAF_RGN_ARRAY;
      else if (b[`ECAF_TYPE_MSB:`ECAF_TYPE_LSB] == `ECAF_TYPE_REGS)
        decode_rgn = `ECAF_RGN_REGS;
    end
  endfunction

  // ========================================================================
  // Synchronised inputs
  wire scl_s;   // Clock pin after two flops
  wire sda_s;   // Data pin after two flops
  wire wp_s;    // Protect pin after two flops
  wire a0_s;
  wire a1_s;
  wire a2_s;
  ecaf_sync u_scl (.clk(clk), .d(scl_i),           .q(scl_s));
  ecaf_sync u_sda (.clk(clk), .d(sda_i),           .q(sda_s));
  ecaf_sync u_wp  (.clk(clk), .d(wp_i),            .q(wp_s));
  ecaf_sync u_a0  (.clk(clk), .d(strap_addr_bit0), .q(a0_s));
  ecaf_sync u_a1  (.clk(clk), .d(strap_addr_bit1), .q(a1_s));
  ecaf_sync u_a2  (.clk(clk), .d(strap_addr_bit2), .q(a2_s));

  reg        scl_d1_q;  // Previous clock sample
  reg        sda_d1_q;  // Previous data sample
  reg [12:0] hold_cnt_q; // Hold-off counter
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg [2:0]  bit_cnt_q;  // Bits received in address byte
  reg [7:0]  shift_q;    // Address shifter
  reg        byte_full_q; // Eight address bits taken since the last start
  reg [2:0]  rgn_d;

  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  // Data edges while clock high are conditions, not bits
  wire start_ev = ready_q & scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire stop_ev  = ready_q & scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // ========================================================================
  // Edge history
  always @(posedge clk)
  begin
    if (srst)
    begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  // ========================================================================
  // Power-on hold-off; bus ignored until it expires
  always @(posedge clk)
  begin
    if (srst)
    begin
      hold_cnt_q <= 13'h0_000;
      ready_q    <= 1'b0;
    end
    else if (!ready_q)
    begin
      if (hold_cnt_q == HOLDOFF_CYC[12:0] - 13'h0_001)
        ready_q <= 1'b1;
      else
        hold_cnt_q <= hold_cnt_q + 13'h0_001;
    end
  end

  // ========================================================================
  // Next state
  always @*
  begin
    state_d = state_q;
    rgn_d   = decode_rgn(shift_q, {a2_s, a1_s, a0_s});
    if (!ready_q)
      state_d = ST_IDLE;
    else if (start_ev)
      state_d = ST_ADDR;
    else if (stop_ev)
      state_d = ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_ADDR:
        begin
          // Eighth bit sampled: decide on the following clock fall
          if (scl_fall && byte_full_q)
            state_d = (rgn_d != `ECAF_RGN_NONE && !write_busy) ? ST_ACK
                                                               : ST_DONE;
        end
        ST_ACK:  if (scl_fall) state_d = ST_DONE;
        ST_DONE: state_d = ST_DONE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // State, shifter and address outputs
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      addr_byte_q <= 8'h00;
      byte_full_q <= 1'b0;
      selected_q  <= 1'b0;
      region_q    <= `ECAF_RGN_NONE;
      read_q      <= 1'b0;
      start_q     <= 1'b0;
      stop_q      <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      start_q <= start_ev;
      stop_q  <= stop_ev;
      if (start_ev)
      begin
        bit_cnt_q   <= 3'h0;
        byte_full_q <= 1'b0;
        selected_q  <= 1'b0;
        region_q   <= `ECAF_RGN_NONE;
      end
      else if (stop_ev)
      begin
        selected_q <= 1'b0;
        region_q   <= `ECAF_RGN_NONE;
      end
      else if (state_q == ST_ADDR && scl_rise)
      begin
        // Bits are sampled on the rising clock, MSB first
        shift_q   <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          // Byte complete: the next clock fall opens the acknowledge slot
          addr_byte_q <= {shift_q[6:0], sda_s};
          byte_full_q <= 1'b1;
        end
      end
      if (state_q == ST_ADDR && state_d == ST_ACK)
      begin
        selected_q <= 1'b1;
        region_q   <= rgn_d;
        read_q     <= shift_q[`ECAF_RW_BIT];
      end
    end
  end

  // ========================================================================
  // Acknowledge drive: pull data low for the whole slot
  always @(posedge clk)
  begin
    if (srst)
    begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_o  <= 1'b0;
      sda_oe <= (state_d == ST_ACK) & ~write_busy;
    end
  end

  // ========================================================================
  // Write permission
  always @(posedge clk)
  begin
    if (srst)
    begin
      array_wr_ok_q <= 1'b0;
      sec_wr_ok_q   <= 1'b0;
      cfg_wr_ok_q   <= 1'b0;
      idpg_wr_ok_q  <= 1'b0;
    end
    else
    begin
      // Pin ignored under software protection; reads never gated
      array_wr_ok_q <= sw_prot_mode | ~wp_s;
      sec_wr_ok_q   <= sw_prot_mode | ~wp_s;
      cfg_wr_ok_q   <= ~cfg_locked;
      idpg_wr_ok_q  <= (sw_prot_mode | ~wp_s) & ~id_page_locked;
    end
  end
endmodule
`default_nettype wire

// File: ecaf_front_assertions.sv
// Port checker for the client address front end.
// Assumes one clock domain and a bind onto ecaf_front.
`timescale 1ns/1ps
`default_nettype none
module ecaf_front_chk
#(
  parameter HOLDOFF_CYC = 8 // Hold-off length of the design
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sda_oe,
  input wire logic wp_i,
  input wire logic sw_prot_mode,
  input wire logic cfg_locked,
  input wire logic write_busy,
  input wire logic ready_q,
  input wire logic selected_q,
  input wire logic array_wr_ok_q,
  input wire logic sec_wr_ok_q,
  input wire logic cfg_wr_ok_q,
  input wire logic start_q,
  input wire logic stop_q
);
  // ========
  // Helpers
  int cyc_q; // Cycles since reset release, saturating
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Count the hold-off from release
  always @(posedge clk)
  begin
    if (srst) cyc_q <= 0;
    else if (cyc_q < HOLDOFF_CYC) cyc_q <= cyc_q + 1;
  end
  // Acknowledge slot: line pulled and device selected
  sequence s_ack_slot;
    (sda_oe && selected_q)[*4];
  endsequence
  AST_HOLDOFF: assert property (ready_q |-> cyc_q >= HOLDOFF_CYC - 1)
    else $error("ready too early");
  AST_QUIET_EARLY: assert property (!ready_q |-> !sda_oe)
    else $error("ack before ready");
  AST_BUSY_NOACK: assert property ($rose(sda_oe) |-> !$past(write_busy))
    else $error("ack while busy");
  AST_ACK_SLOT: assert property ($rose(sda_oe) |-> s_ack_slot)
    else $error("ack slot broken");
  AST_WP_OPEN: assert property ((!wp_i)[*4] |=> array_wr_ok_q && sec_wr_ok_q)
    else $error("writes blocked");
  AST_WP_BLOCK: assert property ((wp_i && !sw_prot_mode)[*4] |=> !array_wr_ok_q)
    else $error("writes not blocked");
  AST_SW_IGNORE: assert property (sw_prot_mode[*2] |=> array_wr_ok_q)
    else $error("protect pin not ignored");
  AST_CFG_LOCK: assert property (cfg_locked[*2] |=> !cfg_wr_ok_q)
    else $error("locked config writable");
  AST_START_ONE: assert property (start_q |=> !start_q && !stop_q)
    else $error("start pulse too long");
endmodule
bind ecaf_front ecaf_front_chk #(.HOLDOFF_CYC(HOLDOFF_CYC)) chk_u
(
  .clk           (clk),
  .srst          (srst),
  .sda_oe        (sda_oe),
  .wp_i          (wp_i),
  .sw_prot_mode  (sw_prot_mode),
  .cfg_locked    (cfg_locked),
  .write_busy    (write_busy),
  .ready_q       (ready_q),
  .selected_q    (selected_q),
  .array_wr_ok_q (array_wr_ok_q),
  .sec_wr_ok_q   (sec_wr_ok_q),
  .cfg_wr_ok_q   (cfg_wr_ok_q),
  .start_q       (start_q),
  .stop_q        (stop_q)
);
`default_nettype wire

// File: ecaf_host.sv
// Host model: drives serial clock and data of the two-wire bus.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ecaf_host
(
  input  wire logic clk,      // Pacing clock, 8 cycles per bit
  input  wire logic sda_line, // Resolved data line
  output var  logic scl,      // Serial clock, idle high
  output var  logic sda_h     // Data drive, high means released
);
  // ========
  // Bus phases
  initial
  begin
    scl = 1'h1;
    sda_h = 1'h1;
  end
  // Set both lines, then wait n falling edges
  task automatic step(input logic c, input logic d, input int n);
    scl = c;
    sda_h = d;
    repeat (n) @(negedge clk);
  endtask
  // Clock low first, data moves only while it is low
  task automatic low(input logic d);
    step(1'h0, sda_h, 1);
    step(1'h0, d, 3);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    low(1'h1);
    step(1'h1, 1'h1, 3);
    step(1'h1, 1'h0, 4);
  endtask
  // Eight bits high first, then sample the acknowledge mid-pulse
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      low(b[i]);
      step(1'h1, b[i], 4);
    end
    low(1'h1);
    step(1'h1, 1'h1, 2);
    ack = !sda_line;
    step(1'h1, 1'h1, 2);
  endtask
  // Stop: data rises with clock high
  task automatic stop();
    low(1'h0);
    step(1'h1, 1'h0, 2);
    step(1'h1, 1'h1, 6);
  endtask
endmodule
`default_nettype wire

// File: test_eeprom_client_address_front_end.sv
// Self-checking bench for the client address front end.
// Assumes design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ecaf_defs.vh"
module test_eeprom_client_address_front_end;
  localparam int HO = 200; // Shortened hold-off
  // ========
  // Signals
  logic clk, srst, wp_i, sw_prot_mode, cfg_locked, id_page_locked, write_busy, ack, en;
  logic strap_addr_bit0, strap_addr_bit1, strap_addr_bit2, ready_q, selected_q, read_q;
  logic sda_o, sda_oe, start_q, stop_q, array_wr_ok_q, sec_wr_ok_q, cfg_wr_ok_q, idpg_wr_ok_q;
  logic [2:0] region_q;
  logic [7:0] addr_byte_q;
  wire        scl_i;
  wire        sda_h;
  wire        sda_i = sda_oe ? 1'h0 : sda_h; // Open drain with pull-up
  int         failures, total_checks, n_ev, cyc;
  // Address bytes, straps 101: good, mismatches, bad type, reserved codes
  logic [7:0] tb_b [9] = '{8'hAA, 8'hAB, 8'hBA, 8'hA8, 8'hAE, 8'hA2, 8'hCA, 8'hF9, 8'h08};
  logic [8:0] tb_a = 9'h187;
  logic [2:0] tb_r [9] = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h4};
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Count start and stop pulses, and cycles since release
  always @(posedge clk)
  begin
    n_ev <= n_ev + int'(start_q === 1'h1) + int'(stop_q === 1'h1);
    cyc <= srst ? 0 : cyc + 1;
  end
  ecaf_front #(.HOLDOFF_CYC(HO)) dut_u
  (
    .clk, .srst, .scl_i, .sda_i, .sda_o, .sda_oe, .strap_addr_bit0, .strap_addr_bit1,
    .strap_addr_bit2, .wp_i, .sw_prot_mode, .cfg_locked, .id_page_locked, .write_busy,
    .ready_q, .selected_q, .region_q, .read_q, .array_wr_ok_q, .sec_wr_ok_q, .cfg_wr_ok_q,
    .idpg_wr_ok_q, .start_q, .stop_q, .addr_byte_q
  );
  ecaf_host host_u (.clk(clk), .sda_line(sda_i), .scl(scl_i), .sda_h(sda_h));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One addressed transfer closed by a stop
  task automatic xfer(input logic [7:0] b, input logic ea, input logic [2:0] er);
    int e0;
    e0 = n_ev;
    host_u.start();
    host_u.send_byte(b, ack);
    chk("ack", ea, ack);
    chk("selected", ea, selected_q);
    chk("drive value", 0, sda_o);
    if (ea)
    begin
      chk("region", er, region_q);
      chk("direction", b[0], read_q);
      chk("byte", b, addr_byte_q);
    end
    host_u.stop();
    chk("start stop", 2, n_ev - e0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {srst, wp_i, sw_prot_mode, cfg_locked, id_page_locked, write_busy} = 6'h20;
    {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0} = 3'h5;
    repeat (6) @(negedge clk);
    srst = 1'h0;
    host_u.start();
    host_u.send_byte(8'hAA, ack);
    chk("early ack", 0, ack);
    host_u.stop();
    for (int i = 0; i < 400 && ready_q !== 1'h1; i++) @(negedge clk);
    chk("hold-off", 1, cyc >= HO - 1 && cyc <= HO + 2);
    wp_i = 1'h1;
    for (int k = 0; k < 9; k++) xfer(tb_b[k], tb_a[k], tb_r[k]);
    write_busy = 1'h1;
    xfer(8'hAA, 1'h0, 3'h0);
    write_busy = 1'h0;
    for (int k = 0; k < 16; k++)
    begin
      {wp_i, sw_prot_mode, cfg_locked, id_page_locked} = k[3:0];
      en = sw_prot_mode | ~wp_i;
      repeat (5) @(negedge clk);
      chk("wr ok", {en, en, ~cfg_locked, en & ~id_page_locked}, {array_wr_ok_q, sec_wr_ok_q,
          cfg_wr_ok_q, idpg_wr_ok_q});
    end
    // Mid-run reset: hold-off starts again and the bus is ignored
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    chk("reset ready", 0, ready_q);
    host_u.start();
    host_u.send_byte(8'hAB, ack);
    chk("reset ack", 0, ack);
    host_u.stop();
    chk("reset hold", 0, ready_q);
    summarize();
  end
  // Watchdog against a hung bus
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
